// *** eil_chk.sv ***
// assertions on the ports of the external interrupt latch
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
module eil_chk (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        extIntPinN,
  input wire logic        levelModeWrEn,
  input wire logic        maskWrEn,
  input wire logic        maskWrData,
  input wire logic        ackWrite,
  input wire logic        vectorFetchAck,
  input wire logic        conditionCodeIMask,
  input wire logic        breakState,
  input wire logic        breakClearEnable,
  input wire logic        extIntPendingFlag,
  input wire logic        extIntMask,
  input wire logic        levelMode,
  input wire logic        ackReadback,
  input wire logic        extIntRequest,
  input wire logic        branchIfPinHigh,
  input wire logic        branchIfPinLow,
  input wire logic [15:0] vectorAddrHi,
  input wire logic [15:0] vectorAddrLo
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_req; extIntRequest == (extIntPendingFlag && !extIntMask && !conditionCodeIMask); endproperty
  a_req: assert property (p_req) else $error("request gating");
  property p_const; !ackReadback && vectorAddrHi == 16'hfffa && vectorAddrLo == 16'hfffb; endproperty
  a_const: assert property (p_const) else $error("constant outputs");
  property p_pin; !extIntPinN [*3] |-> branchIfPinLow && !branchIfPinHigh; endproperty
  a_pin: assert property (p_pin) else $error("pin level");
  property p_set; $fell(branchIfPinHigh) |-> ##[1:2] extIntPendingFlag; endproperty
  a_set: assert property (p_set) else $error("no set");
  // pin high for two samples rules out a pending edge, which would win
  property p_clr; (ackWrite || vectorFetchAck) && !levelMode && !breakState && branchIfPinHigh
    && $past(branchIfPinHigh) |=> !extIntPendingFlag; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  // an earlier counted ack in level mode may still clear on the pin's return high, so leave that case out
  property p_brk; ackWrite && breakState && !breakClearEnable && !vectorFetchAck && !levelModeWrEn
    && !$past(levelModeWrEn) && (branchIfPinLow || !levelMode)
    && extIntPendingFlag |=> extIntPendingFlag; endproperty
  a_brk: assert property (p_brk) else $error("break clear");
  property p_lvl; levelMode && !levelModeWrEn && extIntPendingFlag && branchIfPinLow |=> extIntPendingFlag; endproperty
  a_lvl: assert property (p_lvl) else $error("level hold");
  property p_mask; maskWrEn |=> extIntMask == $past(maskWrData); endproperty
  a_mask: assert property (p_mask) else $error("mask write");
endmodule : eil_chk
bind external_interrupt_latch eil_chk i_eil_chk (.*);

// *** eil_edge_detect.sv ***
// falling-edge detector on the synchronised pin
// assumes its input is already in the ref_clk domain
`timescale 1ns/10ps
module eil_edge_detect (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic pinSync,
  output logic      fallPulse
);

  logic pinPrev;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pinPrev <= eil_pkg::RST_PIN_SYNC;
    end else begin
      pinPrev <= pinSync;
    end
  end

  // high in one sampled cycle, low in the next
  assign fallPulse = pinPrev & ~pinSync;

endmodule : eil_edge_detect

// *** eil_pin_src.sv ***
// external source on the active-low interrupt pin
// assumes a pull-up: the pin idles high when not pulled low
`timescale 1ns/10ps
module eil_pin_src (
  input  wire logic ref_clk,
  input  wire logic lowReq,
  output logic      pinN
);
  // single driver: the first edge already shows the pulled-up level while the block is in reset
  always_ff @(posedge ref_clk) pinN <= !lowReq;
endmodule : eil_pin_src

// *** eil_pin_sync.sv ***
// two-stage synchroniser for the active-low interrupt pin
// assumes the pin idles high; resets to the idle level
`timescale 1ns/10ps
module eil_pin_sync (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic pinIn,
  output logic      pinSync
);

  logic stage1;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage1  <= eil_pkg::RST_PIN_SYNC;
      pinSync <= eil_pkg::RST_PIN_SYNC;
    end else begin
      stage1  <= pinIn;
      pinSync <= stage1;
    end
  end

endmodule : eil_pin_sync

// *** eil_pkg.sv ***
// package for the external interrupt latch: reset values, vector address, latch state codes
// assumes a single 10 MHz clock domain and no register bus
package eil_pkg;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_LATCH      = 1'b0;
  localparam logic RST_LEVEL_MODE = 1'b0;
  localparam logic RST_MASK       = 1'b0;
  localparam logic RST_PIN_SYNC   = 1'b1;

  // ----------------------------------------
  // vector location and timing
  // ----------------------------------------
  localparam logic [15:0] VECTOR_ADDR_HI = 16'hfffa;
  localparam logic [15:0] VECTOR_ADDR_LO = 16'hfffb;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          SYNC_STAGES    = 2;

  // ----------------------------------------
  // latch state
  // ----------------------------------------
  typedef enum logic [1:0] {
    EIL_IDLE    = 2'b00,
    EIL_PENDING = 2'b01,
    EIL_ACKED   = 2'b10
  } eil_state_e;

endpackage : eil_pkg

// *** external_interrupt_latch.sv ***
// external interrupt latch: active-low pin, edge or edge-and-level sensitivity
// assumes the cpu core supplies vector-fetch acknowledge, global mask and break state
//
// Notes on behaviour
// - a low on the interrupt pin can set the request latch
// - vector fetch of this interrupt clears the latch; in level mode only once the pin is high
// - software writing one to acknowledge clears the latch, with conditions
// - reset clears the latch unconditionally
// - edge-only after reset; level select adds low-level sensitivity
// - edge mode: a vector fetch, or a software ack outside break or with break clear enable, clears the latch immediately
// - level mode: clear needs acknowledge and pin high, either order
// - reset clears the level select bit too
// - local mask blocks forwarding to priority logic
// - cpu global interrupt mask also blocks the request
// - falling edge after software acknowledge sets the latch again
// - serviced request vectors through addresses fffa and fffb
// - level mode: pending flag stays set while pin is low
// - pending flag ignores the mask bit
// - pin level is readable for branch-if-high and branch-if-low
// - in break, software acknowledge clears only with break clear enable
// - a latch cleared in break stays cleared after break
// - break clear enable defaults zero; software acks in break then do nothing
// - acknowledge bit is write-only and reads zero
`timescale 1ns/10ps
module external_interrupt_latch (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        extIntPinN,
  input  wire logic        levelModeWrEn,
  input  wire logic        levelModeWrData,
  input  wire logic        maskWrEn,
  input  wire logic        maskWrData,
  input  wire logic        ackWrite,
  input  wire logic        vectorFetchAck,
  input  wire logic        conditionCodeIMask,
  input  wire logic        breakState,
  input  wire logic        breakClearEnable,
  output logic             extIntPendingFlag,
  output logic             extIntMask,
  output logic             levelMode,
  output logic             ackReadback,
  output logic             extIntRequest,
  output logic [15:0]      vectorAddrHi,
  output logic [15:0]      vectorAddrLo,
  output logic             branchIfPinHigh,
  output logic             branchIfPinLow
);

  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------
  logic pinSync;
  logic fallPulse;

  eil_pin_sync uSync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pinIn   (extIntPinN),
    .pinSync (pinSync)
  );

  eil_edge_detect uEdge (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .pinSync   (pinSync),
    .fallPulse (fallPulse)
  );

  // ----------------------------------------
  // configuration bits
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      levelMode <= eil_pkg::RST_LEVEL_MODE;
    end else if (levelModeWrEn) begin
      levelMode <= levelModeWrData;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      extIntMask <= eil_pkg::RST_MASK;
    end else if (maskWrEn) begin
      extIntMask <= maskWrData;
    end
  end

  // ----------------------------------------
  // acknowledge qualification
  // ----------------------------------------
  // in break, a software ack only counts with break clear enable set;
  // the enable itself lives outside and defaults to zero there
  logic swAck;
  logic anyAck;
  logic setReq;

  assign swAck  = ackWrite & (~breakState | breakClearEnable);
  assign anyAck = swAck | vectorFetchAck;

  // a new edge in the ack cycle wins, so no request is lost
  assign setReq = fallPulse;

  // ----------------------------------------
  // latch state machine
  // ----------------------------------------
  eil_pkg::eil_state_e state;
  eil_pkg::eil_state_e next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      eil_pkg::EIL_IDLE: begin
        if (setReq) begin
          next_state = eil_pkg::EIL_PENDING;
        end
      end
      eil_pkg::EIL_PENDING: begin
        if (setReq) begin
          next_state = eil_pkg::EIL_PENDING;
        end else if (anyAck && !levelMode) begin
          next_state = eil_pkg::EIL_IDLE;
        end else if (anyAck && pinSync) begin
          next_state = eil_pkg::EIL_IDLE;
        end else if (anyAck) begin
          next_state = eil_pkg::EIL_ACKED;
        end
      end
      eil_pkg::EIL_ACKED: begin
        // acked but pin still low; waits for its return high
        if (setReq) begin
          next_state = eil_pkg::EIL_PENDING;
        end else if (!levelMode || pinSync) begin
          next_state = eil_pkg::EIL_IDLE;
        end
      end
      default: begin
        next_state = eil_pkg::EIL_IDLE;
      end
    endcase
  end

  // cleared state persists after break since nothing re-sets it but an edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= eil_pkg::EIL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic latchSet;
  assign latchSet = (state != eil_pkg::EIL_IDLE);

  // pending ignores the mask; in level mode held while pin low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      extIntPendingFlag <= eil_pkg::RST_LATCH;
    end else begin
      extIntPendingFlag <= (next_state != eil_pkg::EIL_IDLE);
    end
  end

  assign extIntRequest   = latchSet & ~extIntMask & ~conditionCodeIMask;
  assign ackReadback     = 1'b0;
  assign vectorAddrHi    = eil_pkg::VECTOR_ADDR_HI;
  assign vectorAddrLo    = eil_pkg::VECTOR_ADDR_LO;
  assign branchIfPinHigh = pinSync;
  assign branchIfPinLow  = ~pinSync;

endmodule : external_interrupt_latch

// *** external_interrupt_latch_bench.sv ***
// bench: table of trigger cases, then level, vector, break and reset cases
// assumes eil_pin_src on the pin and eil_chk bound to the design
`timescale 1ns/10ps
module external_interrupt_latch_bench;
  logic ref_clk, nrst, extIntPinN, levelModeWrEn, levelModeWrData, maskWrEn, maskWrData, ackWrite;
  logic vectorFetchAck, conditionCodeIMask, breakState, breakClearEnable, extIntPendingFlag;
  logic extIntMask, levelMode, ackReadback, extIntRequest, branchIfPinHigh, branchIfPinLow, pinLow;
  int fails = 0;
  int n_checks = 0;
  // {mode, mask, global mask, expected request}
  logic [3:0] rows [4] = '{4'h1, 4'h4, 4'h2, 4'h9};
  external_interrupt_latch i_external_interrupt_latch (.vectorAddrHi(), .vectorAddrLo(), .*);
  eil_pin_src i_eil_pin_src (.ref_clk(ref_clk), .lowReq(pinLow), .pinN(extIntPinN));
  initial begin
    ref_clk = 1'h0;
    forever #(eil_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic pulse(input logic [1:0] w);
    {ackWrite, vectorFetchAck} <= w;
    cyc(1);
    {ackWrite, vectorFetchAck} <= 2'h0;
    cyc(1);
  endtask : pulse
  task automatic cfg(input logic m, input logic k);
    {levelModeWrEn, levelModeWrData, maskWrEn, maskWrData} <= {1'h1, m, 1'h1, k};
    cyc(1);
    {levelModeWrEn, maskWrEn} <= 2'h0;
  endtask : cfg
  // six cycles cover source, synchroniser and latch
  task automatic pin(input logic v);
    pinLow <= v;
    cyc(6);
  endtask : pin
  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    {nrst, pinLow, levelModeWrEn, levelModeWrData, maskWrEn, maskWrData} = 6'h0;
    {ackWrite, vectorFetchAck, conditionCodeIMask, breakState, breakClearEnable} = 5'h0;
    cyc(12);
    chk({extIntPendingFlag, extIntMask, levelMode, ackReadback, extIntRequest, branchIfPinHigh}, 8'h1);
    nrst <= 1'h1;
    foreach (rows[i]) begin
      cfg(rows[i][3], rows[i][2]);
      conditionCodeIMask <= rows[i][1];
      pin(1'h1);
      chk({extIntPendingFlag, extIntRequest}, {1'h1, rows[i][0]});
      pin(1'h0);
      pulse(2'h2);
      chk(extIntPendingFlag, 8'h0);
    end
    pin(1'h1);
    cfg(1'h1, 1'h1);
    pulse(2'h2);
    chk({extIntPendingFlag, extIntRequest}, 8'h2);
    pin(1'h0);
    chk(extIntPendingFlag, 8'h0);
    cfg(1'h0, 1'h0);
    pin(1'h1);
    pin(1'h0);
    pulse(2'h1);
    chk(extIntPendingFlag, 8'h0);
    breakState <= 1'h1;
    pin(1'h1);
    pin(1'h0);
    pulse(2'h2);
    chk(extIntPendingFlag, 8'h1);
    breakClearEnable <= 1'h1;
    pulse(2'h2);
    breakState <= 1'h0;
    cyc(2);
    chk(extIntPendingFlag, 8'h0);
    pin(1'h1);
    chk(extIntPendingFlag, 8'h1);
    cfg(1'h1, 1'h0);
    nrst <= 1'h0;
    cyc(2);
    chk({extIntPendingFlag, levelMode}, 8'h0);
    // pin back high before release, so the synchroniser's idle value is not followed by a low sample
    pinLow <= 1'h0;
    cyc(2);
    nrst <= 1'h1;
    cyc(8);
    chk({extIntPendingFlag, levelMode, branchIfPinHigh}, 8'h1);
    stop_test();
  end
  initial begin
    cyc(1000);
    fails++;
    stop_test();
  end
endmodule : external_interrupt_latch_bench
